// ---- rtl/pll_control_register_block.sv ----
`timescale 1ns/1ns
// What this block does
// - three-bit charge pump current, eight steps 110uA to 880uA, resets to 100
// - two-bit loop series resistor select, rising with code, resets to 01
// - two-bit parallel capacitor select 40/80/140/200pF, resets to 01
// - second-pole bit picks low or high post resistor, resets to 1
// - lock count bit: 1 ppm cleared, 16 ppm set, resets to 1
// - manual override bit: automatic lock when clear, manual when set, resets clear
// - oscillator select: second oscillator when clear, first when set, resets set
// - first oscillator manual lock code applied in manual mode, resets to 01011
// - second oscillator manual lock code applied in manual mode, resets to zero
// - bypass bit drives outputs zero to three from reference, resets clear
// - reference output high-impedance when enable clear, else carries selected reference
// - prescaler mode: divide by 1, 2, 4, or multiply by 2; resets 11
module pll_control_register_block (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // configuration port
  input  wire logic [15:0] reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata_q,
  // device pins
  input  wire logic        bypass_pin,
  input  wire logic        clk_sel_pin,
  // loop filter and charge pump settings
  output logic      [2:0]  charge_pump_current_sel_q,
  output logic      [1:0]  loop_series_res_sel_q,
  output logic      [1:0]  loop_parallel_cap_sel_q,
  output logic             second_pole_sel_q,
  // lock detector settings
  output logic             lock_count_accuracy_q,
  output logic             lock_manual_override_q,
  output logic      [4:0]  lock_code_q,
  // reference and bypass path
  output logic             synth_bypass_q,
  output logic             ref_out_en_n_q,
  output logic             ref_src_clk_q,
  output logic      [1:0]  prescale_mode_q
);

  // field storage not seen directly at the ports, apart from prescale_q driven straight onto prescale_mode_q
  logic                          manual_osc_select_q;
  logic [4:0]                    osc1_manual_lock_code_q;
  logic [4:0]                    osc2_manual_lock_code_q;
  logic                          synth_bypass_bit_q;
  logic                          refout_en_q;
  pll_ctrl_pkg::prescale_type    prescale_q;

  // address decode
  wire hit_filter = (reg_addr == pll_ctrl_pkg::ADDR_LOOP_FILTER);
  wire hit_lock   = (reg_addr == pll_ctrl_pkg::ADDR_LOCK_DETECT);
  wire hit_osc1   = (reg_addr == pll_ctrl_pkg::ADDR_OSC1_LOCK);
  wire hit_osc2   = (reg_addr == pll_ctrl_pkg::ADDR_OSC2_LOCK);
  wire hit_byp    = (reg_addr == pll_ctrl_pkg::ADDR_BYPASS_REF);
  wire hit_spare  = (reg_addr == pll_ctrl_pkg::ADDR_SPARE);
  wire hit_any    = hit_filter | hit_lock | hit_osc1 | hit_osc2 | hit_byp;

  // write strobes; spare register takes no write
  wire wr_filter  = reg_wr & hit_filter;
  wire wr_lock    = reg_wr & hit_lock;
  wire wr_osc1    = reg_wr & hit_osc1;
  wire wr_osc2    = reg_wr & hit_osc2;
  wire wr_byp     = reg_wr & hit_byp;

  // readback words, reserved positions return zero
  wire [7:0] rb_filter = {charge_pump_current_sel_q, loop_series_res_sel_q,
                          loop_parallel_cap_sel_q, second_pole_sel_q};
  wire [7:0] rb_lock   = {6'h00, lock_count_accuracy_q, lock_manual_override_q};
  wire [7:0] rb_osc1   = {2'h0, manual_osc_select_q, osc1_manual_lock_code_q};
  wire [7:0] rb_osc2   = {3'h0, osc2_manual_lock_code_q};
  wire [7:0] rb_byp    = {3'h0, synth_bypass_bit_q, 1'h0, refout_en_q, prescale_q};

  // read select; unmapped and spare addresses read zero
  wire [7:0] rdata_d = hit_filter ? rb_filter :
                       hit_lock   ? rb_lock   :
                       hit_osc1   ? rb_osc1   :
                       hit_osc2   ? rb_osc2   :
                       hit_byp    ? rb_byp    : 8'h00;

  // loop filter register
  always_ff @(posedge clk) begin
    if (rst) begin
      charge_pump_current_sel_q <= pll_ctrl_pkg::RST_CP_CUR;
      loop_series_res_sel_q     <= pll_ctrl_pkg::RST_SER_RES;
      loop_parallel_cap_sel_q   <= pll_ctrl_pkg::RST_PAR_CAP;
      second_pole_sel_q         <= pll_ctrl_pkg::RST_SECOND_POLE;
    end else if (wr_filter) begin
      charge_pump_current_sel_q <= reg_wdata[pll_ctrl_pkg::CP_CUR_MSB:pll_ctrl_pkg::CP_CUR_LSB];
      loop_series_res_sel_q     <= reg_wdata[pll_ctrl_pkg::SER_RES_MSB:pll_ctrl_pkg::SER_RES_LSB];
      loop_parallel_cap_sel_q   <= reg_wdata[pll_ctrl_pkg::PAR_CAP_MSB:pll_ctrl_pkg::PAR_CAP_LSB];
      second_pole_sel_q         <= reg_wdata[pll_ctrl_pkg::SECOND_POLE_BIT];
    end
  end

  // lock detect register
  always_ff @(posedge clk) begin
    if (rst) begin
      lock_count_accuracy_q  <= pll_ctrl_pkg::RST_LOCK_COUNT;
      lock_manual_override_q <= pll_ctrl_pkg::RST_MANUAL;
    end else if (wr_lock) begin
      lock_count_accuracy_q  <= reg_wdata[pll_ctrl_pkg::LOCK_COUNT_BIT];
      lock_manual_override_q <= reg_wdata[pll_ctrl_pkg::MANUAL_BIT];
    end
  end

  // first oscillator manual lock register
  always_ff @(posedge clk) begin
    if (rst) begin
      manual_osc_select_q     <= pll_ctrl_pkg::RST_OSC_SEL;
      osc1_manual_lock_code_q <= pll_ctrl_pkg::RST_CODE1;
    end else if (wr_osc1) begin
      manual_osc_select_q     <= reg_wdata[pll_ctrl_pkg::OSC_SEL_BIT];
      osc1_manual_lock_code_q <= reg_wdata[pll_ctrl_pkg::CODE_MSB:pll_ctrl_pkg::CODE_LSB];
    end
  end

  // second oscillator manual lock register
  always_ff @(posedge clk) begin
    if (rst) begin
      osc2_manual_lock_code_q <= pll_ctrl_pkg::RST_CODE2;
    end else if (wr_osc2) begin
      osc2_manual_lock_code_q <= reg_wdata[pll_ctrl_pkg::CODE_MSB:pll_ctrl_pkg::CODE_LSB];
    end
  end

  // bypass, reference output and prescaler register
  always_ff @(posedge clk) begin
    if (rst) begin
      synth_bypass_bit_q <= pll_ctrl_pkg::RST_BYPASS;
      refout_en_q        <= pll_ctrl_pkg::RST_REFOUT_EN;
      prescale_q         <= pll_ctrl_pkg::prescale_type'(pll_ctrl_pkg::RST_PRESCALE);
    end else if (wr_byp) begin
      synth_bypass_bit_q <= reg_wdata[pll_ctrl_pkg::BYPASS_BIT];
      refout_en_q        <= reg_wdata[pll_ctrl_pkg::REFOUT_EN_BIT];
      prescale_q         <= pll_ctrl_pkg::prescale_type'(
                              reg_wdata[pll_ctrl_pkg::PRESCALE_MSB:pll_ctrl_pkg::PRESCALE_LSB]);
    end
  end

  // registered read data, held until the next read
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata_q <= rdata_d;
    end
  end

  // prescaler mode to the reference path
  assign prescale_mode_q = prescale_q;

  // hand fields and pins to the path logic
  pll_path_if path_bus ();

  assign path_bus.bypass_bit  = synth_bypass_bit_q;
  assign path_bus.bypass_pin  = bypass_pin;
  assign path_bus.refout_en   = refout_en_q;
  assign path_bus.clk_sel_pin = clk_sel_pin;
  assign path_bus.manual      = lock_manual_override_q;
  assign path_bus.osc_sel     = manual_osc_select_q;
  assign path_bus.code1       = osc1_manual_lock_code_q;
  assign path_bus.code2       = osc2_manual_lock_code_q;

  pll_path_ctrl u_path (
    .clk (clk),
    .rst (rst),
    .p   (path_bus.path)
  );

  // path controls, each a flop inside the path logic
  assign synth_bypass_q = path_bus.bypass_q;
  assign ref_out_en_n_q = path_bus.ref_out_en_n_q;
  assign ref_src_clk_q  = path_bus.ref_src_clk_q;
  assign lock_code_q    = path_bus.lock_code_q;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // reset values seen on the first cycle after release
  chk_cp_reset_value: assert property ($past(rst) |-> charge_pump_current_sel_q == 3'h4)
    else $error("charge pump current reset value wrong");
  chk_filter_reset_value: assert property ($past(rst) |-> loop_series_res_sel_q == 2'h1 &&
                                           loop_parallel_cap_sel_q == 2'h1 && second_pole_sel_q)
    else $error("loop filter reset value wrong");
  chk_lock_reset_value: assert property ($past(rst) |-> lock_count_accuracy_q && !lock_manual_override_q &&
                                         manual_osc_select_q && osc1_manual_lock_code_q == 5'h0B &&
                                         osc2_manual_lock_code_q == 5'h00)
    else $error("lock control reset value wrong");
  chk_byp_reset_value: assert property ($past(rst) |-> !synth_bypass_bit_q && !refout_en_q &&
                                        prescale_mode_q == 2'h3)
    else $error("bypass register reset value wrong");

  // writes land in the right field one cycle later
  chk_cp_write_field: assert property (wr_filter |=> charge_pump_current_sel_q == $past(reg_wdata[7:5]) &&
                                       second_pole_sel_q == $past(reg_wdata[0]))
    else $error("loop filter write not stored");
  chk_prescale_write: assert property (wr_byp |=> prescale_mode_q == $past(reg_wdata[1:0]) &&
                                       synth_bypass_bit_q == $past(reg_wdata[4]))
    else $error("bypass register write not stored");
  chk_lock_count_hold: assert property (!wr_lock |=> $stable(lock_count_accuracy_q))
    else $error("lock count changed without a write");

  // write then read returns the written lock field
  chk_readback_lock: assert property (wr_lock ##1 (reg_rd && hit_lock && !reg_wr)
                                      |=> reg_rdata_q[1:0] == $past(reg_wdata[1:0], 2))
    else $error("lock register readback mismatch");
  chk_spare_zero: assert property (reg_rd && hit_spare |=> reg_rdata_q == 8'h00)
    else $error("spare register did not read zero");
  chk_bypass_port: assert property (bypass_pin |=> ##1 synth_bypass_q || !$past(bypass_pin))
    else $error("bypass pin did not reach outputs");

  // lock and oscillator registers take every field of a write
  chk_lock_write: assert property (wr_lock |=> lock_count_accuracy_q == $past(reg_wdata[1])
                                   && lock_manual_override_q == $past(reg_wdata[0]))
    else $error("lock detect write not stored");
  chk_osc1_write: assert property (wr_osc1 |=> manual_osc_select_q == $past(reg_wdata[5])
                                   && osc1_manual_lock_code_q == $past(reg_wdata[4:0]))
    else $error("first oscillator write not stored");
  chk_osc2_write: assert property (wr_osc2 |=> osc2_manual_lock_code_q == $past(reg_wdata[4:0]))
    else $error("second oscillator write not stored");

  // loop filter and bypass registers take the remaining fields
  chk_res_cap_write: assert property (wr_filter |=> loop_series_res_sel_q == $past(reg_wdata[4:3])
                                      && loop_parallel_cap_sel_q == $past(reg_wdata[2:1]))
    else $error("resistor or capacitor write not stored");
  chk_refout_write: assert property (wr_byp |=> refout_en_q == $past(reg_wdata[2]))
    else $error("reference enable write not stored");

  // fields hold between writes to their register
  chk_filter_hold: assert property (!wr_filter |=> $stable(rb_filter))
    else $error("loop filter changed without a write");
  chk_manual_hold: assert property (!wr_lock |=> $stable(lock_manual_override_q))
    else $error("manual override changed without a write");
  chk_osc1_hold: assert property (!wr_osc1 |=> $stable(rb_osc1))
    else $error("first oscillator changed without a write");
  chk_osc2_hold: assert property (!wr_osc2 |=> $stable(rb_osc2))
    else $error("second oscillator changed without a write");
  chk_byp_hold: assert property (!wr_byp |=> $stable(rb_byp))
    else $error("bypass register changed without a write");

  // stray writes leave every field alone
  chk_unmapped_write: assert property (reg_wr && !hit_any |=> $stable(rb_filter) && $stable(rb_lock)
                                       && $stable(rb_osc1) && $stable(rb_osc2) && $stable(rb_byp))
    else $error("unmapped write changed a field");

  // read data holds until the next read
  chk_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata_q))
    else $error("read data changed without a read");

  // reads return the fields; a same-cycle write shows only later
  chk_read_filter: assert property (reg_rd && hit_filter |=> reg_rdata_q ==
                                    $past({charge_pump_current_sel_q, loop_series_res_sel_q,
                                           loop_parallel_cap_sel_q, second_pole_sel_q}))
    else $error("loop filter readback wrong");
  chk_read_lock: assert property (reg_rd && hit_lock |=> reg_rdata_q ==
                                  $past({6'h00, lock_count_accuracy_q, lock_manual_override_q}))
    else $error("lock detect readback wrong");
  chk_read_osc1: assert property (reg_rd && hit_osc1 |=> reg_rdata_q ==
                                  $past({2'h0, manual_osc_select_q, osc1_manual_lock_code_q}))
    else $error("first oscillator readback wrong");
  chk_read_osc2: assert property (reg_rd && hit_osc2 |=> reg_rdata_q ==
                                  $past({3'h0, osc2_manual_lock_code_q}))
    else $error("second oscillator readback wrong");
  chk_read_byp: assert property (reg_rd && hit_byp |=> reg_rdata_q ==
                                 $past({3'h0, synth_bypass_bit_q, 1'h0, refout_en_q, prescale_mode_q}))
    else $error("bypass register readback wrong");

  // unmapped and spare addresses read zero
  chk_unmapped_read: assert property (reg_rd && !hit_any |=> reg_rdata_q == 8'h00)
    else $error("unmapped address did not read zero");

  // bypass bit reaches the outputs one edge later
  chk_bypass_bit_path: assert property (synth_bypass_bit_q |=> synth_bypass_q)
    else $error("bypass bit did not reach outputs");

  // reference enable drives the active-low pin control
  chk_refout_on: assert property (refout_en_q |=> !ref_out_en_n_q)
    else $error("reference output not driven while enabled");
  chk_refout_off: assert property (!refout_en_q |=> ref_out_en_n_q)
    else $error("reference output driven while off");

  // reference source copied from the select pin each edge
  chk_ref_src_follow: assert property (1'b1 |=> ref_src_clk_q == $past(clk_sel_pin))
    else $error("reference source does not follow the pin");

  // lock code is zero in automatic mode, else the chosen oscillator's code
  chk_lock_code_auto: assert property (!lock_manual_override_q |=> lock_code_q == 5'h00)
    else $error("lock code applied in automatic mode");
  chk_lock_code_osc: assert property (lock_manual_override_q |=> lock_code_q ==
                                      $past(manual_osc_select_q ? osc1_manual_lock_code_q : osc2_manual_lock_code_q))
    else $error("manual lock code from wrong oscillator");

  // main scenarios
  cov_write_bypass: cover property (wr_byp && reg_wdata[4] ##2 synth_bypass_q);
  cov_readback_osc1: cover property (wr_osc1 ##1 reg_rd && hit_osc1);
  cov_refout_on: cover property (wr_byp && reg_wdata[2] ##2 !ref_out_en_n_q);

endmodule : pll_control_register_block

// ---- pkg/pll_ctrl_pkg.sv ----
package pll_ctrl_pkg;

  // register byte addresses on the configuration port
  localparam logic [15:0] ADDR_LOOP_FILTER = 16'h009A;
  localparam logic [15:0] ADDR_LOCK_DETECT = 16'h009B;
  localparam logic [15:0] ADDR_OSC1_LOCK   = 16'h009C;
  localparam logic [15:0] ADDR_OSC2_LOCK   = 16'h009D;
  localparam logic [15:0] ADDR_BYPASS_REF  = 16'h009E;
  localparam logic [15:0] ADDR_SPARE       = 16'h009F;

  // field positions, loop filter register
  localparam int CP_CUR_MSB      = 7;
  localparam int CP_CUR_LSB      = 5;
  localparam int SER_RES_MSB     = 4;
  localparam int SER_RES_LSB     = 3;
  localparam int PAR_CAP_MSB     = 2;
  localparam int PAR_CAP_LSB     = 1;
  localparam int SECOND_POLE_BIT = 0;

  // field positions, lock detect and manual lock registers
  localparam int LOCK_COUNT_BIT  = 1;
  localparam int MANUAL_BIT      = 0;
  localparam int OSC_SEL_BIT     = 5;
  localparam int CODE_MSB        = 4;
  localparam int CODE_LSB        = 0;

  // field positions, bypass / reference output / prescaler register
  localparam int BYPASS_BIT      = 4;
  localparam int REFOUT_EN_BIT   = 2;
  localparam int PRESCALE_MSB    = 1;
  localparam int PRESCALE_LSB    = 0;

  // reset values of every defined field
  localparam logic [2:0] RST_CP_CUR      = 3'h4;
  localparam logic [1:0] RST_SER_RES     = 2'h1;
  localparam logic [1:0] RST_PAR_CAP     = 2'h1;
  localparam logic       RST_SECOND_POLE = 1'h1;
  localparam logic       RST_LOCK_COUNT  = 1'h1;
  localparam logic       RST_MANUAL      = 1'h0;
  localparam logic       RST_OSC_SEL     = 1'h1;
  localparam logic [4:0] RST_CODE1       = 5'h0B;
  localparam logic [4:0] RST_CODE2       = 5'h00;
  localparam logic       RST_BYPASS      = 1'h0;
  localparam logic       RST_REFOUT_EN   = 1'h0;
  localparam logic [1:0] RST_PRESCALE    = 2'h3;

  // manual oscillator choice: set picks the first oscillator
  localparam logic OSC_SEL_FIRST = 1'h1;

  // reference prescaler modes
  typedef enum logic [1:0] {
    PRE_DIV1 = 2'b00,
    PRE_DIV2 = 2'b01,
    PRE_DIV4 = 2'b10,
    PRE_MUL2 = 2'b11
  } prescale_type;

endpackage : pll_ctrl_pkg

// ---- pkg/pll_path_if.sv ----
`timescale 1ns/1ns
interface pll_path_if;
  // register fields and pins handed to the path logic
  logic       bypass_bit;
  logic       bypass_pin;
  logic       refout_en;
  logic       clk_sel_pin;
  logic       manual;
  logic       osc_sel;
  logic [4:0] code1;
  logic [4:0] code2;
  // registered controls coming back
  logic       bypass_q;
  logic       ref_out_en_n_q;
  logic       ref_src_clk_q;
  logic       lock_manual_q;
  logic [4:0] lock_code_q;

  modport bank (output bypass_bit, bypass_pin, refout_en, clk_sel_pin, manual, osc_sel, code1, code2,
                input  bypass_q, ref_out_en_n_q, ref_src_clk_q, lock_manual_q, lock_code_q);
  modport path (input  bypass_bit, bypass_pin, refout_en, clk_sel_pin, manual, osc_sel, code1, code2,
                output bypass_q, ref_out_en_n_q, ref_src_clk_q, lock_manual_q, lock_code_q);
endinterface : pll_path_if

// ---- rtl/pll_path_ctrl.sv ----
`timescale 1ns/1ns
module pll_path_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // fields in, controls out
  pll_path_if.path p
);

  // bypass follows pin or bit; reference output driven only when enabled
  wire bypass_d = p.bypass_pin | p.bypass_bit;
  wire lock_first = (p.osc_sel == pll_ctrl_pkg::OSC_SEL_FIRST);
  wire [4:0] code_d = lock_first ? p.code1 : p.code2;

  // registered path controls
  always_ff @(posedge clk) begin
    if (rst) begin
      p.bypass_q       <= 1'h0;
      p.ref_out_en_n_q <= 1'h1;
      p.ref_src_clk_q  <= 1'h0;
      p.lock_manual_q  <= 1'h0;
      p.lock_code_q    <= 5'h00;
    end else begin
      p.bypass_q       <= bypass_d;
      p.ref_out_en_n_q <= ~p.refout_en;
      p.ref_src_clk_q  <= p.clk_sel_pin;
      p.lock_manual_q  <= p.manual;
      p.lock_code_q    <= p.manual ? code_d : 5'h00;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // either source of bypass reaches the outputs next cycle
  chk_bypass_or_path: assert property ((p.bypass_pin || p.bypass_bit) |=> p.bypass_q)
    else $error("bypass not active after pin or bit");
  chk_bypass_off: assert property (!p.bypass_pin && !p.bypass_bit |=> !p.bypass_q)
    else $error("bypass active with pin and bit low");
  chk_refout_hiz: assert property (!p.refout_en |=> p.ref_out_en_n_q)
    else $error("reference output driven while disabled");
  chk_lock_code_first: assert property (p.manual && p.osc_sel |=> p.lock_code_q == $past(p.code1))
    else $error("first oscillator code not applied");
  chk_lock_code_second: assert property (p.manual && !p.osc_sel |=> p.lock_code_q == $past(p.code2))
    else $error("second oscillator code not applied");
  chk_manual_mode: assert property ($rose(p.manual) |=> p.lock_manual_q ##1 p.lock_manual_q || !p.manual)
    else $error("manual lock not followed");

  cov_manual_second: cover property (p.manual && !p.osc_sel ##1 p.lock_manual_q);
  cov_pin_bypass: cover property (p.bypass_pin && !p.bypass_bit ##1 p.bypass_q);

endmodule : pll_path_ctrl

// ---- tb/tb.sv ----
`timescale 1ns/1ns
module tb;
  // clock, reset and port signals
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] reg_addr = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_wdata = 8'h00;
  logic [7:0]  reg_rdata_q;
  logic        bypass_pin = 1'b0;
  logic        clk_sel_pin = 1'b0;
  logic [2:0]  charge_pump_current_sel_q;
  logic [1:0]  loop_series_res_sel_q;
  logic [1:0]  loop_parallel_cap_sel_q;
  logic        second_pole_sel_q;
  logic        lock_count_accuracy_q;
  logic        lock_manual_override_q;
  logic [4:0]  lock_code_q;
  logic        synth_bypass_q;
  logic        ref_out_en_n_q;
  logic        ref_src_clk_q;
  logic [1:0]  prescale_mode_q;
  int          mismatches = 0;
  int          n_checks = 0;
  int          cycles = 0;

  // 20 MHz clock
  always #25 clk = ~clk;

  pll_control_register_block u_dut (
    .clk                       (clk),
    .rst                       (rst),
    .reg_addr                  (reg_addr),
    .reg_wr                    (reg_wr),
    .reg_rd                    (reg_rd),
    .reg_wdata                 (reg_wdata),
    .reg_rdata_q               (reg_rdata_q),
    .bypass_pin                (bypass_pin),
    .clk_sel_pin               (clk_sel_pin),
    .charge_pump_current_sel_q (charge_pump_current_sel_q),
    .loop_series_res_sel_q     (loop_series_res_sel_q),
    .loop_parallel_cap_sel_q   (loop_parallel_cap_sel_q),
    .second_pole_sel_q         (second_pole_sel_q),
    .lock_count_accuracy_q     (lock_count_accuracy_q),
    .lock_manual_override_q    (lock_manual_override_q),
    .lock_code_q               (lock_code_q),
    .synth_bypass_q            (synth_bypass_q),
    .ref_out_en_n_q            (ref_out_en_n_q),
    .ref_src_clk_q             (ref_src_clk_q),
    .prescale_mode_q           (prescale_mode_q)
  );

  // closing report and verdict
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim

  // hang guard, well above the expected run length
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches = mismatches + 1;
      $display("BAD %0t timeout", $time);
      end_sim();
    end
  end

  // value compare, four-state exact
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // one strobed write on the configuration port
  task automatic wr(input logic [15:0] addr, input logic [7:0] data);
    @(negedge clk);
    reg_addr = addr;
    reg_wdata = data;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask : wr

  // one strobed read, result compared
  task automatic rd_chk(input logic [15:0] addr, input logic [7:0] exp, input string what);
    @(negedge clk);
    reg_addr = addr;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    chk(reg_rdata_q, exp, what);
  endtask : rd_chk

  // write then read on the very next edge, result compared
  task automatic wr_rd_chk(input logic [15:0] addr, input logic [7:0] data, input string what);
    @(negedge clk);
    reg_addr = addr;
    reg_wdata = data;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    chk(reg_rdata_q, data, what);
  endtask : wr_rd_chk

  // synchronous reset held for a number of cycles
  task automatic do_reset(input int n);
    @(negedge clk);
    rst = 1'b1;
    repeat (n) @(negedge clk);
    rst = 1'b0;
  endtask : do_reset

  // every field and path output except ref_src_clk_q at its default
  task automatic check_defaults();
    chk({5'h0, charge_pump_current_sel_q}, 8'h04, "cp rst");
    chk({6'h0, loop_series_res_sel_q}, 8'h01, "res rst");
    chk({6'h0, loop_parallel_cap_sel_q}, 8'h01, "cap rst");
    chk({7'h0, second_pole_sel_q}, 8'h01, "pole rst");
    chk({7'h0, lock_count_accuracy_q}, 8'h01, "lcnt rst");
    chk({7'h0, lock_manual_override_q}, 8'h00, "man rst");
    chk({3'h0, lock_code_q}, 8'h00, "code rst");
    chk({7'h0, synth_bypass_q}, 8'h00, "byp rst");
    chk({7'h0, ref_out_en_n_q}, 8'h01, "refoe rst");
    chk({6'h0, prescale_mode_q}, 8'h03, "pre rst");
    rd_chk(16'h009A, 8'h8B, "9A rst");
    rd_chk(16'h009B, 8'h02, "9B rst");
    rd_chk(16'h009C, 8'h2B, "9C rst");
    rd_chk(16'h009D, 8'h00, "9D rst");
    rd_chk(16'h009E, 8'h03, "9E rst");
  endtask : check_defaults

  // main sequence
  initial begin
    logic [2:0] c;
    logic [7:0] wd;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    check_defaults();
    $display("test defaults done");
    // loop filter codes, every charge pump step
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      wd = {c, c[1:0], c[2:1], c[0]};
      wr(16'h009A, wd);
      chk({5'h0, charge_pump_current_sel_q}, {5'h0, c}, "cp");
      chk({6'h0, loop_series_res_sel_q}, {6'h0, c[1:0]}, "res");
      chk({6'h0, loop_parallel_cap_sel_q}, {6'h0, c[2:1]}, "cap");
      chk({7'h0, second_pole_sel_q}, {7'h0, c[0]}, "pole");
      rd_chk(16'h009A, wd, "9A rb");
    end
    $display("test loop filter done");
    // manual lock code selection, software keeps reserved bits zero
    wr(16'h009C, 8'h35);
    wr(16'h009D, 8'h0A);
    wr(16'h009B, 8'h00);
    @(negedge clk);
    chk({7'h0, lock_count_accuracy_q}, 8'h00, "lcnt clr");
    chk({3'h0, lock_code_q}, 8'h00, "code auto");
    wr(16'h009B, 8'h01);
    @(negedge clk);
    chk({7'h0, lock_manual_override_q}, 8'h01, "man set");
    chk({3'h0, lock_code_q}, 8'h15, "code osc1");
    wr(16'h009C, 8'h15);
    @(negedge clk);
    chk({3'h0, lock_code_q}, 8'h0A, "code osc2");
    rd_chk(16'h009C, 8'h15, "9C rb");
    rd_chk(16'h009D, 8'h0A, "9D rb");
    wr_rd_chk(16'h009B, 8'h03, "9B b2b");
    $display("test manual lock done");
    // bypass or-ing, reference output enable, prescale modes
    for (int i = 0; i < 4; i++) begin
      c = i[2:0];
      bypass_pin = c[1];
      clk_sel_pin = c[1];
      wd = {3'h0, c[0], 1'b0, c[0] ^ c[1], c[1:0]};
      wr(16'h009E, wd);
      chk({6'h0, prescale_mode_q}, {6'h0, c[1:0]}, "pre");
      @(negedge clk);
      chk({7'h0, synth_bypass_q}, {7'h0, c[0] | c[1]}, "byp");
      chk({7'h0, ref_out_en_n_q}, {7'h0, ~(c[0] ^ c[1])}, "refoe");
      chk({7'h0, ref_src_clk_q}, {7'h0, c[1]}, "refsrc");
      rd_chk(16'h009E, wd, "9E rb");
    end
    $display("test bypass done");
    // unmapped and aliased addresses leave the bank alone
    wr(16'h019A, 8'h00);
    wr(16'h00A0, 8'hFF);
    rd_chk(16'h009A, 8'hFF, "alias 9A");
    rd_chk(16'h00A0, 8'h00, "unmapped rd");
    rd_chk(16'h009F, 8'h00, "spare rd");
    $display("test unmapped done");
    // second reset in mid-run
    bypass_pin = 1'b0;
    clk_sel_pin = 1'b0;
    do_reset(2);
    check_defaults();
    $display("test second reset done");
    end_sim();
  end
endmodule : tb
